// [srm_pkg.sv]
// Package for the system reset manager: register map, fields and timing counts.
package srm_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 20000000;
	localparam int unsigned PULSE_MIN_US = 20;
	// Least pulse time in whole cycles; cycles per microsecond round down.
	localparam int unsigned PULSE_CYC    = (PULSE_MIN_US * (CLK_HZ / 1000000));
	localparam int unsigned PCNT_W       = 10;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CAUSE = 8'h00;
	localparam logic [7:0] OFF_BDCTL = 8'h04;
	localparam logic [7:0] OFF_IRQST = 8'h08;
	localparam logic [7:0] OFF_IRQMK = 8'h0c;
	localparam logic [7:0] OFF_STATE = 8'h10;

	// ------------------------------------------------------------
	// Cause flag positions
	// ------------------------------------------------------------
	localparam int unsigned C_PIN   = 0;
	localparam int unsigned C_WWD   = 1;
	localparam int unsigned C_IWD   = 2;
	localparam int unsigned C_SW    = 3;
	localparam int unsigned C_PWR   = 4;
	localparam int unsigned C_LPM   = 5;
	localparam int unsigned C_BKP   = 6;
	localparam int unsigned NCAUSE  = 7;
	localparam int unsigned BD_SWR  = 0;
	localparam int unsigned CLR_BIT = 31;

	localparam logic [NCAUSE-1:0] CAUSE_RST = 7'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_PULSE = 2'b01,
		ST_HOLD  = 2'b10
	} srm_state_t;

	typedef struct packed {
		logic window_watchdog;
		logic independent_watchdog;
		logic core_reset_request;
		logic standby_req;
		logic stop_req;
		logic reset_on_standby_opt;
		logic reset_on_stop_opt;
	} srm_req_t;

	typedef struct packed {
		logic power_on;
		logic power_down_detect;
		logic brownout_detect;
		logic standby_wake;
		logic supply_repower;
	} srm_pwr_t;

endpackage

// [srm_sync.sv]
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/100ps
module srm_sync
	import srm_pkg::*;
#(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] INIT = '0
)
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// Levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} srm_sync_t;

	srm_sync_t st_q;
	srm_sync_t st_d;

	// ------------------------------------------------------------
	// Logic
	// ------------------------------------------------------------
	// First stage is read only by the second stage.
	always_comb
	begin
		st_d    = st_q;
		st_d.s1 = d_i;
		st_d.s2 = st_q.s1;
	end

	// Both stages take the initial level under reset.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q <= {INIT, INIT};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign q_o = st_q.s2;

endmodule

// [srm_top.sv]
// System reset manager: reset sources, pin pulse, cause flags and APB registers.
// Contract
// - Low reset pin starts a system reset.
// - Watchdogs, software, power, low-power start reset.
// - Record reset cause in status flags.
// - System reset keeps cause flags and backup.
// - Core reset request bit triggers software reset.
// - Stop or standby with option resets instead.
// - Reset pin held low throughout system reset.
// - Internal requests pulse pin low 20 us.
// - Power reset on power-on, power-down, brownout, wake.
// - Power reset clears all including cause flags; here only power-on clears, and only the cause flags.
// - Backup software bit triggers backup reset.
// - Supply repower after total loss resets backup.
// - Backup reset touches only backup registers.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
module srm_top
	import srm_pkg::*;
(
	// Clock and power reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_B_I,
	// Reset pin, three signals of an open-drain pin
	input  wire logic        EXT_RESET_PIN_N_I,
	output logic             EXT_RESET_PIN_N_O,
	output logic             EXT_RESET_PIN_N_OE_O,
	// Request sources
	input  wire srm_req_t    REQ_I,
	input  wire srm_pwr_t    PWR_I,
	// Reset scopes and low-power entry
	output logic             SYS_RESET_O,
	output logic             BKP_RESET_O,
	output logic             LP_ENTER_O,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Interrupt
	output logic             IRQ_O
);

	typedef struct packed {
		srm_state_t        state;
		logic [PCNT_W-1:0] cnt;
		logic [NCAUSE-1:0] cause;
		logic [NCAUSE-1:0] irq_st;
		logic [NCAUSE-1:0] irq_mk;
		logic              bd_swr;
		logic              pin_drv;
		logic              sys_rst;
		logic              bkp_rst;
		logic              lp_en;
		logic [31:0]       rdata;
		logic              ready;
		logic              slverr;
		logic              irq;
	} srm_st_t;

	srm_st_t st_q;
	srm_st_t st_d;

	// Synchronised copies of the pin and the asynchronous sources.
	logic              pin_s;
	srm_req_t          req_s;
	srm_pwr_t          pwr_s;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Pin idles high; requests and monitors idle low.
	srm_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
		.clk_i   (SYS_CLK_I),
		.rst_b_i (RST_B_I),
		.d_i     (EXT_RESET_PIN_N_I),
		.q_o     (pin_s)
	);

	srm_sync #(.W($bits(srm_req_t)), .INIT('0)) u_req_sync (
		.clk_i   (SYS_CLK_I),
		.rst_b_i (RST_B_I),
		.d_i     (REQ_I),
		.q_o     (req_s)
	);

	srm_sync #(.W($bits(srm_pwr_t)), .INIT('0)) u_pwr_sync (
		.clk_i   (SYS_CLK_I),
		.rst_b_i (RST_B_I),
		.d_i     (PWR_I),
		.q_o     (pwr_s)
	);

	// ------------------------------------------------------------
	// Request decoding
	// ------------------------------------------------------------
	logic power_rst;
	logic lp_rst;
	logic lp_plain;
	logic [NCAUSE-1:0] int_src;
	logic apb_wr;
	logic bus_setup;

	// Power events; low-power requests with options set become resets.
	always_comb
	begin
		power_rst = pwr_s.power_on | pwr_s.power_down_detect
			| pwr_s.brownout_detect | pwr_s.standby_wake;
		lp_rst    = (req_s.standby_req & req_s.reset_on_standby_opt)
			| (req_s.stop_req & req_s.reset_on_stop_opt);
		lp_plain  = (req_s.standby_req | req_s.stop_req) & ~lp_rst;
		int_src          = '0;
		int_src[C_WWD]   = req_s.window_watchdog;
		int_src[C_IWD]   = req_s.independent_watchdog;
		int_src[C_SW]    = req_s.core_reset_request;
		int_src[C_PWR]   = power_rst;
		int_src[C_LPM]   = lp_rst;
		bus_setup = PSEL_I & ~PENABLE_I;
		apb_wr    = PSEL_I & PENABLE_I & st_q.ready & PWRITE_I;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Sequencer, cause flags, backup reset and register access.
	always_comb
	begin
		logic [NCAUSE-1:0] ev;
		ev   = '0;
		st_d = st_q;
		st_d.ready  = 1'b0;
		st_d.slverr = 1'b0;
		unique case (st_q.state)
			ST_RUN:
			begin
				if (|int_src)
				begin
					// Internal request: drive the pin low and time the pulse.
					st_d.state   = ST_PULSE;
					st_d.cnt     = '0;
					st_d.pin_drv = 1'b1;
					st_d.sys_rst = 1'b1;
					ev           = int_src;
				end
				else if (!pin_s)
				begin
					// External requester pulls the pin itself.
					st_d.state   = ST_HOLD;
					st_d.sys_rst = 1'b1;
					ev[C_PIN]    = 1'b1;
				end
			end
			ST_PULSE:
			begin
				// Count out the least pulse length, longer while a source persists.
				if (st_q.cnt < PCNT_W'(PULSE_CYC - 1))
				begin
					st_d.cnt = st_q.cnt + PCNT_W'(1);
				end
				else if (!(|int_src))
				begin
					st_d.pin_drv = 1'b0;
					st_d.state   = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				// Release the reset on the clock once the pin reads high.
				if (pin_s)
				begin
					st_d.state   = ST_RUN;
					st_d.sys_rst = 1'b0;
				end
			end
			default:
			begin
				st_d.state = ST_RUN;
			end
		endcase

		// Backup reset from software bit or supply repower only.
		st_d.bkp_rst = st_q.bd_swr | pwr_s.supply_repower;
		if (st_d.bkp_rst)
		begin
			ev[C_BKP] = 1'b1;
		end
		st_d.lp_en = lp_plain & ~st_q.sys_rst;
		// The request bit lasts one cycle; a fresh write in that cycle wins.
		if (st_q.bd_swr)
		begin
			st_d.bd_swr = 1'b0;
		end

		// Software access: a cause write with bit 31 set clears all cause flags, interrupt flags write-one-to-clear, set wins over clear.
		if (apb_wr)
		begin
			unique case (PADDR_I)
				OFF_CAUSE:
				begin
					if (PWDATA_I[CLR_BIT])
					begin
						st_d.cause = '0;
					end
				end
				OFF_BDCTL: st_d.bd_swr = PWDATA_I[BD_SWR];
				OFF_IRQST: st_d.irq_st = st_q.irq_st & ~PWDATA_I[NCAUSE-1:0];
				OFF_IRQMK: st_d.irq_mk = PWDATA_I[NCAUSE-1:0];
				OFF_STATE: ;
				default:   ;
			endcase
		end
		// Cause flags survive system reset; power-on clears them and records itself.
		if (pwr_s.power_on)
		begin
			st_d.cause = '0;
			ev[C_PWR]  = 1'b1;
		end
		st_d.cause  = st_d.cause | ev;
		st_d.irq_st = st_d.irq_st | ev;
		st_d.irq    = |(st_d.irq_st & st_d.irq_mk);

		// Ready goes high in the cycle after setup.
		if (bus_setup)
		begin
			st_d.ready = 1'b1;
			st_d.rdata = '0;
			unique case (PADDR_I)
				OFF_CAUSE: st_d.rdata[NCAUSE-1:0] = st_q.cause;
				OFF_BDCTL: st_d.rdata[BD_SWR]     = st_q.bd_swr;
				OFF_IRQST: st_d.rdata[NCAUSE-1:0] = st_q.irq_st;
				OFF_IRQMK: st_d.rdata[NCAUSE-1:0] = st_q.irq_mk;
				OFF_STATE: st_d.rdata[4:0] = {st_q.bkp_rst, st_q.sys_rst, st_q.state, pin_s};
				default:
				begin
					// Unmapped: the error answer stands beside ready.
					st_d.slverr = 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// RST_B_I is the power reset; everything takes its reset value.
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			st_q        <= '0;
			st_q.state  <= ST_RUN;
			st_q.cause  <= CAUSE_RST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign EXT_RESET_PIN_N_O    = 1'b0;
	assign EXT_RESET_PIN_N_OE_O = st_q.pin_drv;
	assign SYS_RESET_O          = st_q.sys_rst;
	assign BKP_RESET_O          = st_q.bkp_rst;
	assign LP_ENTER_O           = st_q.lp_en;
	assign PRDATA_O             = st_q.rdata;
	assign PREADY_O             = st_q.ready;
	assign PSLVERR_O            = st_q.slverr;
	assign IRQ_O                = st_q.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	pin_start_a: assert property ((st_q.state == ST_RUN && !pin_s && !(|int_src))
		|=> st_q.sys_rst && st_q.cause[C_PIN]) else $error("pin low gave no reset");
	int_start_a: assert property ((st_q.state == ST_RUN && |int_src)
		|=> st_q.sys_rst && st_q.pin_drv) else $error("internal request ignored");
	cause_keep_a: assert property ((st_q.cause[C_WWD] && !pwr_s.power_on && !apb_wr)
		|=> st_q.cause[C_WWD]) else $error("cause flag lost");
	sw_cause_a: assert property ((st_q.state == ST_RUN && req_s.core_reset_request)
		|=> st_q.cause[C_SW]) else $error("software cause not set");
	lp_block_a: assert property (lp_rst |=> !st_q.lp_en) else $error("low-power entered");
	pin_hold_a: assert property (st_q.sys_rst
		|-> st_q.pin_drv || st_q.state == ST_HOLD) else $error("reset without pin low");
	pulse_len_a: assert property ($fell(st_q.pin_drv)
		|-> st_q.cnt == PCNT_W'(PULSE_CYC - 1)) else $error("pulse too short");
	pwr_clear_a: assert property (pwr_s.power_on && !req_s.window_watchdog
		|=> !st_q.cause[C_WWD]) else $error("power reset kept flags");
	bkp_sw_a: assert property (st_q.bd_swr |=> st_q.bkp_rst)
		else $error("backup reset missing");
	bkp_pwr_a: assert property (pwr_s.supply_repower |=> st_q.bkp_rst)
		else $error("repower reset missing");
	bkp_only_a: assert property ($rose(st_q.bkp_rst) && st_q.state == ST_RUN
		&& !(|int_src) && pin_s |=> !st_q.sys_rst) else $error("backup hit system");
	release_a: assert property ((st_q.state == ST_HOLD && pin_s) |=> !st_q.sys_rst)
		else $error("reset not released");
	power_a: assert property (st_q.state == ST_RUN && pwr_s.brownout_detect
		|=> st_q.sys_rst ##0 st_q.cause[C_PWR]) else $error("brownout missed");

	pulse_c: cover property ($fell(st_q.pin_drv));
	ext_c: cover property (st_q.state == ST_RUN && !pin_s);
	bkp_c: cover property ($rose(st_q.bkp_rst));
	irq_c: cover property ($rose(st_q.irq));

endmodule

// [srm_pin_model.sv]
// Open-drain reset pin with pull-up and the external reset circuitry on it.
`timescale 1ns/100ps
module srm_pin_model
(
	// Clock for the slow release
	input  wire logic       clk_i,
	// Device side of the pin
	input  wire logic       dev_o_i,
	input  wire logic       dev_oe_i,
	// External requester and release delay in cycles
	input  wire logic       press_i,
	input  wire logic [3:0] slow_i,
	// Wire level
	output logic            pin_o
);
	logic [3:0] hold_q = 4'h0;

	// A slow filter keeps the pin low a few cycles after the device lets go.
	always_ff @(posedge clk_i)
		hold_q <= (dev_oe_i && !dev_o_i) ? slow_i : hold_q - {3'h0, hold_q != 4'h0};

	// The pull-up wins only while nobody pulls low; the requester pulls low directly.
	assign pin_o = ((dev_oe_i && !dev_o_i) || press_i || hold_q != 4'h0) ? 1'b0 : 1'b1;
endmodule

// [tb_top.sv]
// Self-checking bench for the system reset manager.
`timescale 1ns/100ps
module tb_top;
	import srm_pkg::*;
	typedef struct packed
	{
		srm_req_t   r;
		srm_pwr_t   p;
		logic [6:0] c;
	} srm_row_t;

	logic        clk;
	logic        rst_b;
	logic        psel;
	logic        pen;
	logic        pwr_w;
	logic        press;
	logic [3:0]  slow;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        pin;
	logic        pin_o;
	logic        pin_oe;
	logic        sys_rst;
	logic        bkp_rst;
	logic        lp_en;
	logic        irq;
	srm_req_t    req;
	srm_pwr_t    pwr;
	int          errors;
	int          n_compared;
	int          n;
	int          k;
	// Each internal source and the cause flags it should leave behind.
	srm_row_t    rows [9] = '{{7'h40, 5'h00, 7'h02}, {7'h20, 5'h00, 7'h04},
		{7'h10, 5'h00, 7'h08}, {7'h0a, 5'h00, 7'h20}, {7'h05, 5'h00, 7'h20},
		{7'h00, 5'h10, 7'h10}, {7'h00, 5'h08, 7'h10}, {7'h00, 5'h04, 7'h10},
		{7'h00, 5'h02, 7'h10}};

	srm_top srm_top_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b), .EXT_RESET_PIN_N_I(pin),
		.EXT_RESET_PIN_N_O(pin_o), .EXT_RESET_PIN_N_OE_O(pin_oe), .REQ_I(req),
		.PWR_I(pwr), .SYS_RESET_O(sys_rst), .BKP_RESET_O(bkp_rst), .LP_ENTER_O(lp_en),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr_w), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.IRQ_O(irq));

	srm_pin_model srm_pin_model_inst (.clk_i(clk), .dev_o_i(pin_o), .dev_oe_i(pin_oe),
		.press_i(press), .slow_i(slow), .pin_o(pin));

	// Free-running system clock.
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error land in rd and er.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr_w <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Ready, data and error are taken at the rising edge that sees ready high.
		@(posedge clk);
		while (pready !== 1'b1 && t < 20)
		begin
			@(posedge clk);
			t++;
		end
		chk(t < 20, 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// Raise one internal source, follow the pin pulse and read the cause.
	task automatic fire(input srm_row_t x);
		int t;
		int g;
		int o;
		t = 0;
		g = 0;
		// The first cycle of the drive was already seen when the reset rose.
		o = 1;
		@(posedge clk);
		req <= x.r;
		pwr <= x.p;
		slow <= x.c[4] ? 4'h6 : 4'h0;
		while (sys_rst !== 1'b1 && t < 20)
		begin
			@(negedge clk);
			t++;
		end
		chk({sys_rst, pin_oe}, 2'b11);
		@(posedge clk);
		req <= '0;
		pwr <= '0;
		t = 0;
		@(negedge clk);
		while ((pin_oe === 1'b1 || pin === 1'b0) && t < 1000)
		begin
			t++;
			g += (sys_rst === 1'b1);
			o += (pin_oe === 1'b1);
			@(negedge clk);
		end
		chk(o >= PULSE_CYC, 1'b1);
		chk(g, t);
		repeat (4) @(negedge clk);
		chk(sys_rst, 1'b0);
		apb(1'b0, OFF_CAUSE, 32'h0);
		chk(rd, {25'h0, x.c});
		apb(1'b1, OFF_CAUSE, 32'h8000_0000);
	endtask

	task conclude;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence: reset values, the table, then the awkward cases.
	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr_w = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		req = '0;
		pwr = '0;
		press = 1'b0;
		slow = 4'h0;
		errors = 0;
		n_compared = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (k = 0; k < 5; k++)
		begin
			apb(1'b0, 8'(k * 4), 32'h0);
			chk(rd, (k == 4) ? 32'h1 : 32'h0);
		end
		$display("test reset values done");
		for (k = 0; k < 9; k++)
			fire(rows[k]);
		$display("test internal sources done");
		@(posedge clk);
		press <= 1'b1;
		repeat (10) @(negedge clk);
		chk(sys_rst, 1'b1);
		@(posedge clk);
		press <= 1'b0;
		repeat (5) @(negedge clk);
		chk(sys_rst, 1'b0);
		apb(1'b0, OFF_CAUSE, 32'h0);
		chk(rd, 32'h1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, OFF_CAUSE, 32'h0);
		chk(rd, 32'h0);
		$display("test external pin done");
		apb(1'b1, OFF_IRQMK, 32'h40);
		for (n = 0; n < 2; n++)
		begin
			apb(1'b1, OFF_BDCTL, 32'h1);
			k = 0;
			repeat (6)
			begin
				@(negedge clk);
				k += bkp_rst + 4 * sys_rst;
			end
			chk(k, 1);
			chk(irq, !n);
			apb(1'b0, OFF_IRQST, 32'h0);
			chk(rd, 32'h40);
			apb(1'b1, OFF_IRQST, 32'h40);
			apb(1'b1, OFF_IRQMK, 32'h0);
			@(negedge clk);
			chk(irq, 1'b0);
		end
		apb(1'b0, OFF_CAUSE, 32'h0);
		chk(rd, 32'h40);
		$display("test backup and interrupt done");
		@(posedge clk);
		pwr <= 5'h01;
		repeat (6) @(negedge clk);
		chk({bkp_rst, sys_rst}, 2'b10);
		@(posedge clk);
		pwr <= '0;
		repeat (6) @(negedge clk);
		chk(bkp_rst, 1'b0);
		for (k = 0; k < 2; k++)
		begin
			@(posedge clk);
			req <= k ? 7'h04 : 7'h08;
			repeat (5) @(negedge clk);
			chk({lp_en, sys_rst}, 2'b10);
			@(posedge clk);
			req <= '0;
		end
		apb(1'b0, 8'h20, 32'h0);
		chk({er, rd[0]}, 2'b10);
		$display("test repower, low power and unmapped done");
		conclude;
	end

	// Cuts a hang short well after the tests should have ended.
	initial
	begin
		#(30000 * 50);
		errors++;
		conclude;
	end
endmodule
